// ==== hub_cfg_pkg.sv ====
// package: offsets, field positions and reset values of the hub configuration bytes
package hub_cfg_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] product_code_high_off    = 8'h04;
  localparam logic [7:0] device_configuration_off = 8'h05;

  // ----------------------------------------------------------------------
  // field positions inside device_configuration
  // ----------------------------------------------------------------------
  localparam int custom_text_enable_bit     = 7;
  localparam int custom_serial_enable_bit   = 6;
  localparam int low_power_link_inhibit_bit = 5;
  localparam int indicator_select_n_bit     = 4;
  localparam int ganged_power_bit           = 3;
  localparam int reduced_power_mgmt_n_bit   = 2;
  localparam int link_idle_timeout_force_bit = 1;
  localparam int reserved_bit               = 0;

  // ----------------------------------------------------------------------
  // values after reset and fixed values
  // ----------------------------------------------------------------------
  localparam logic [7:0] product_code_high_rst = 8'h5a; // arbitrary value
  localparam logic [7:0] config_writable_mask  = 8'hfe; // bit 0 read-only
  localparam logic [7:0] timeout_forced_value  = 8'hff;
  localparam logic [7:0] timeout_zero_value    = 8'h00;
  localparam logic [7:0] unmapped_read_value   = 8'h00;

  // cycles after reset release before straps are taken (sync depth)
  localparam logic [1:0] strap_capture_cycles  = 2'h2;

  // ----------------------------------------------------------------------
  // strap pins sampled at reset release
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic serial_data_strap;
    logic indicator_strap_addr3;
    logic gang_strap_addr2;
    logic powermgmt_strap_addr1;
    logic serial_clock_strap;
  } strap_type;

  // one byte write from a configuration source
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } byte_write_type;

endpackage

// ==== hub_device_config_regs.sv ====
// design: hub product-code high byte and device configuration byte
//
// Function
// R1: read-write product code high byte at offset 4h, replaceable by configuration.
// R2: custom text enable in I2C mode enables loading string registers from EEPROM.
// R3: custom text enable in SMBus mode lets the host write string registers.
// R4: custom serial enable gates serial-number load (I2C) or host writes (SMBus).
// R5: custom text and custom serial enables reset to zero, not strapped.
// R6: inhibit bit set blocks initiating or accepting U1/U2 on all ports.
// R7: after Force_LinkPM_Accept, U1/U2 allowed until power-on reset or disconnect.
// R8: inhibit bit default comes from serial-data strap at reset release.
// R9: indicator select default from indicator strap, also SMBus address bit 3.
// R10: ganged power default from gang strap, also SMBus address bit 2.
// R11: reduced power mgmt default from strap; zero means switching and overcurrent.
// R12: reduced mode, bus powered: power switching only, no overcurrent detection.
// R13: in I2C mode EEPROM values replace the strap-sampled configuration bits.
// R14: in SMBus mode host writes overwrite strap bits before configuration ends.
// R15: reduced mode, self powered: overcurrent detection only, no power switching.
// R16: timeout force maps programmed timeout 1..FF to FF, zero stays zero.
// R17: configuration bit 0 is reserved, read-only zero.
// R18: ganged power switches all ports together, all off on any overcurrent; here all off only while overcurrent_supported.
`timescale 1ns/10ps
`default_nettype none

module hub_device_config_regs
  import hub_cfg_pkg::*;
#(
  parameter int num_ports = 4
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // strap pins, asynchronous to mclk
  input  wire strap_type            straps,
  // mode selection from the configuration front end
  input  wire logic                 i2c_mode,
  input  wire logic                 smbus_mode,
  input  wire logic                 host_cfg_active,
  // byte writes from the EEPROM loader and from the SMBus slave
  input  wire byte_write_type       eeprom_write,
  input  wire byte_write_type       host_write,
  // byte read port
  input  wire logic [7:0]           read_addr,
  output logic [7:0]                read_data,
  // link power management events
  input  wire logic                 force_accept_event,
  input  wire logic                 upstream_disconnect,
  output logic                      low_power_permit,
  // power topology
  input  wire logic                 self_powered,
  output logic                      power_switch_supported,
  output logic                      overcurrent_supported,
  // downstream timeout
  input  wire logic [7:0]           sw_link_timeout,
  output logic [7:0]                link_timeout,
  // downstream port power, overcurrent pins are asynchronous
  input  wire logic [num_ports-1:0] port_power_request,
  input  wire logic [num_ports-1:0] port_overcurrent,
  output logic [num_ports-1:0]      port_power_on,
  // string and serial access permissions
  output logic                      string_load_enable,
  output logic                      string_host_write_enable,
  output logic                      serial_load_enable,
  output logic                      serial_host_write_enable,
  // configuration bytes and strapped SMBus address bits
  output logic [7:0]                product_code_high,
  output logic [7:0]                device_configuration,
  output logic [2:0]                smbus_addr_bits
);

  // ----------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------
  if (num_ports < 1 || num_ports > 8) begin : g_bad_ports
    $error("num_ports must be 1 to 8");
  end

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // a write targets the given offset
  function automatic logic hits(input byte_write_type w,
                                input logic [7:0] off);
    hits = w.wr && (w.addr == off);
  endfunction

  // ----------------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------------
  strap_type                 strap_meta_r;
  strap_type                 strap_sync_r;
  logic [num_ports-1:0]      oc_meta_r;
  logic [num_ports-1:0]      oc_sync_r;
  logic [1:0]                capture_cnt_r;
  logic                      capture_done_r;
  logic                      force_accept_r;
  logic [7:0]                prod_r;
  logic [7:0]                cfg_r;
  logic [7:0]                cfg_nxt;
  logic                      eeprom_ok;
  logic                      host_ok;
  logic                      capture_now;

  // two flops on strap and overcurrent pins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strap_meta_r <= '0;
      strap_sync_r <= '0;
      oc_meta_r    <= '0;
      oc_sync_r    <= '0;
    end else begin
      strap_meta_r <= straps;
      strap_sync_r <= strap_meta_r;
      oc_meta_r    <= port_overcurrent;
      oc_sync_r    <= oc_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------------
  // wait until the synchroniser holds real pin levels, then take them once
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      capture_cnt_r  <= '0;
      capture_done_r <= 1'b0;
    end else if (!capture_done_r) begin
      if (capture_cnt_r == strap_capture_cycles) begin
        capture_done_r <= 1'b1;
      end else begin
        capture_cnt_r <= capture_cnt_r + 2'h1;
      end
    end
  end

  // the single edge at which the synchronised straps are taken
  assign capture_now = !capture_done_r &&
                       capture_cnt_r == strap_capture_cycles;

  // EEPROM writes count only in I2C mode, host writes only in SMBus mode
  assign eeprom_ok = capture_done_r && i2c_mode; // R13
  assign host_ok   = capture_done_r && smbus_mode && host_cfg_active; // R14

  // ----------------------------------------------------------------------
  // product code high byte
  // ----------------------------------------------------------------------
  // host write is later than the EEPROM load, so it takes precedence
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prod_r <= product_code_high_rst;
    end else if (host_ok && hits(host_write, product_code_high_off)) begin
      prod_r <= host_write.data; // R1
    end else if (eeprom_ok && hits(eeprom_write, product_code_high_off)) begin
      prod_r <= eeprom_write.data; // R1
    end
  end

  // ----------------------------------------------------------------------
  // device configuration byte
  // ----------------------------------------------------------------------
  // next value: strap capture first, then configuration writes
  always_comb begin
    cfg_nxt = cfg_r;
    if (capture_now) begin
      cfg_nxt[low_power_link_inhibit_bit] =
        strap_sync_r.serial_data_strap; // R8
      cfg_nxt[indicator_select_n_bit] =
        strap_sync_r.indicator_strap_addr3; // R9
      cfg_nxt[ganged_power_bit] = strap_sync_r.gang_strap_addr2; // R10
      cfg_nxt[reduced_power_mgmt_n_bit] =
        strap_sync_r.powermgmt_strap_addr1; // R11
      cfg_nxt[link_idle_timeout_force_bit] =
        strap_sync_r.serial_clock_strap;
    end else if (host_ok && hits(host_write, device_configuration_off)) begin
      cfg_nxt = host_write.data & config_writable_mask; // R14
    end else if (eeprom_ok &&
                 hits(eeprom_write, device_configuration_off)) begin
      cfg_nxt = eeprom_write.data & config_writable_mask; // R13
    end
    cfg_nxt[reserved_bit] = 1'b0; // R17
  end

  // enables reset to zero, strapped bits wait for capture
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_r <= '0; // R5
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // strapped SMBus address bits follow the same capture
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      smbus_addr_bits <= '0;
    end else if (capture_now) begin
      smbus_addr_bits <= {strap_sync_r.indicator_strap_addr3,
                          strap_sync_r.gang_strap_addr2,
                          strap_sync_r.powermgmt_strap_addr1}; // R9 R10
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  // registered read, unmapped offsets return zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      read_data <= unmapped_read_value;
    end else begin
      case (read_addr)
        product_code_high_off:    read_data <= prod_r;
        device_configuration_off: read_data <= cfg_r; // R17
        default:                  read_data <= unmapped_read_value;
      endcase
    end
  end

  // register copies for the outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      product_code_high    <= product_code_high_rst;
      device_configuration <= '0;
    end else begin
      product_code_high    <= prod_r;
      device_configuration <= cfg_r;
    end
  end

  // ----------------------------------------------------------------------
  // string and serial permissions
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      string_load_enable       <= 1'b0;
      string_host_write_enable <= 1'b0;
      serial_load_enable       <= 1'b0;
      serial_host_write_enable <= 1'b0;
    end else begin
      string_load_enable <= cfg_r[custom_text_enable_bit] && i2c_mode; // R2
      string_host_write_enable <=
        cfg_r[custom_text_enable_bit] && smbus_mode; // R3
      serial_load_enable <=
        cfg_r[custom_serial_enable_bit] && i2c_mode; // R4
      serial_host_write_enable <=
        cfg_r[custom_serial_enable_bit] && smbus_mode; // R4
    end
  end

  // ----------------------------------------------------------------------
  // link low-power permission
  // ----------------------------------------------------------------------
  // sticky force-accept; a new event wins over a disconnect in one cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      force_accept_r <= 1'b0;
    end else if (force_accept_event) begin
      force_accept_r <= 1'b1; // R7
    end else if (upstream_disconnect) begin
      force_accept_r <= 1'b0; // R7
    end
  end

  // U1/U2 permitted unless inhibited and no force-accept seen
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_power_permit <= 1'b0;
    end else begin
      low_power_permit <= !cfg_r[low_power_link_inhibit_bit] ||
                          force_accept_r || force_accept_event; // R6 R7
    end
  end

  // ----------------------------------------------------------------------
  // power topology and timeout
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      power_switch_supported <= 1'b0;
      overcurrent_supported  <= 1'b0;
    end else if (!cfg_r[reduced_power_mgmt_n_bit]) begin
      power_switch_supported <= 1'b1; // R11
      overcurrent_supported  <= 1'b1; // R11
    end else begin
      power_switch_supported <= !self_powered; // R12 R15
      overcurrent_supported  <= self_powered; // R12 R15
    end
  end

  // forced timeout: nonzero becomes FF, zero stays zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link_timeout <= timeout_zero_value;
    end else if (cfg_r[link_idle_timeout_force_bit] &&
                 sw_link_timeout != timeout_zero_value) begin
      link_timeout <= timeout_forced_value; // R16
    end else begin
      link_timeout <= sw_link_timeout; // R16
    end
  end

  // ----------------------------------------------------------------------
  // downstream port power
  // ----------------------------------------------------------------------
  // ganged: all on together, all off on any overcurrent while overcurrent_supported; else per port
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_power_on <= '0;
    end else if (cfg_r[ganged_power_bit]) begin
      if (overcurrent_supported && |oc_sync_r) begin
        port_power_on <= '0; // R18
      end else begin
        port_power_on <= {num_ports{|port_power_request}}; // R18
      end
    end else if (overcurrent_supported) begin
      port_power_on <= port_power_request & ~oc_sync_r;
    end else begin
      port_power_on <= port_power_request;
    end
  end

endmodule // hub_device_config_regs

`default_nettype wire

// ==== hub_cfg_sva.sv ====
// checker: timing relations of the hub configuration byte outputs
`timescale 1ns/10ps
`default_nettype none

module hub_cfg_sva
  import hub_cfg_pkg::*;
#(
  parameter int num_ports = 4
) (
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire logic [7:0]           read_addr,
  input wire logic [7:0]           read_data,
  input wire logic                 force_accept_event,
  input wire logic                 low_power_permit,
  input wire logic                 self_powered,
  input wire logic                 power_switch_supported,
  input wire logic                 overcurrent_supported,
  input wire logic [7:0]           sw_link_timeout,
  input wire logic [7:0]           link_timeout,
  input wire logic [num_ports-1:0] port_overcurrent,
  input wire logic [num_ports-1:0] port_power_on,
  input wire logic [7:0]           product_code_high,
  input wire logic [7:0]           device_configuration
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------------
  sequence s_force_seen;
    force_accept_event;
  endsequence
  // pin overcurrent reaches the port logic while ganged with detection on
  sequence s_oc_ganged;
    (|port_overcurrent) ##3
      (device_configuration[3] && $past(overcurrent_supported));
  endsequence

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_reserved_zero: assert property (device_configuration[0] == 1'b0)
    else $error("reserved config bit reads one");
  a_timeout_map: assert property (!$past(rst) |-> link_timeout ==
      ((device_configuration[1] && $past(sw_link_timeout) != 8'h00) ?
       8'hff : $past(sw_link_timeout)))
    else $error("effective link timeout wrong");
  a_power_full: assert property (!$past(rst) && !device_configuration[2]
      |-> power_switch_supported && overcurrent_supported)
    else $error("full power management support missing");
  a_power_reduced: assert property (!$past(rst) &&
      device_configuration[2]
      |-> power_switch_supported == !$past(self_powered) &&
          overcurrent_supported == $past(self_powered))
    else $error("reduced power management support wrong");
  a_inhibit_hold: assert property ($rose(low_power_permit) &&
      device_configuration[5] |-> $past(force_accept_event))
    else $error("low power permitted while inhibited");
  a_force_sticky: assert property (s_force_seen |=> low_power_permit[*2])
    else $error("forced accept did not permit low power");
  a_ganged_trip: assert property (s_oc_ganged |-> port_power_on == '0)
    else $error("ganged ports not all off on overcurrent");
  a_ganged_same: assert property (!$past(rst) && device_configuration[3]
      |-> (&port_power_on) || !(|port_power_on))
    else $error("ganged ports differ");
  a_read_product: assert property (read_addr == 8'h04
      |=> read_data == product_code_high)
    else $error("product code read wrong");
  a_read_config: assert property (read_addr == 8'h05
      |=> read_data == device_configuration)
    else $error("configuration read wrong");
endmodule // hub_cfg_sva

bind hub_device_config_regs hub_cfg_sva #(.num_ports(num_ports)) u_sva (
  .mclk(mclk), .rst(rst), .read_addr(read_addr), .read_data(read_data),
  .force_accept_event(force_accept_event),
  .low_power_permit(low_power_permit), .self_powered(self_powered),
  .power_switch_supported(power_switch_supported),
  .overcurrent_supported(overcurrent_supported),
  .sw_link_timeout(sw_link_timeout), .link_timeout(link_timeout),
  .port_overcurrent(port_overcurrent), .port_power_on(port_power_on),
  .product_code_high(product_code_high),
  .device_configuration(device_configuration));

`default_nettype wire

// ==== cfg_source_model.sv ====
// partner model: smbus host and serial eeprom issuing byte writes
`timescale 1ns/10ps
`default_nettype none

module cfg_source_model
  import hub_cfg_pkg::*;
(
  input  wire logic         mclk,
  output var byte_write_type host_write,
  output var byte_write_type eeprom_write
);
  // idle strobes at time zero
  initial begin
    host_write   = '0;
    eeprom_write = '0;
  end

  // one-cycle host byte write; released fields show the inverse
  task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk) host_write <= {1'b1, a, d};
    @(negedge mclk) host_write <= {1'b0, ~a, ~d};
  endtask

  // one-cycle eeprom loader byte write
  task automatic eep_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk) eeprom_write <= {1'b1, a, d};
    @(negedge mclk) eeprom_write <= {1'b0, ~a, ~d};
  endtask
endmodule // cfg_source_model

`default_nettype wire

// ==== hub_device_config_regs_test.sv ====
// testbench: configuration byte registers against the partner model
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
  fail_count++; $display("BAD t=%0t got %h exp %h", $time, got, exp); end end

module hub_device_config_regs_test;
  import hub_cfg_pkg::*;
  logic           mclk, rst, i2c_mode, smbus_mode, host_cfg_active;
  logic           force_accept_event, upstream_disconnect, self_powered;
  logic           low_power_permit, power_switch_supported;
  logic           overcurrent_supported, string_load_enable;
  logic           string_host_write_enable, serial_load_enable;
  logic           serial_host_write_enable;
  strap_type      straps;
  byte_write_type eeprom_write, host_write;
  logic [7:0]     read_addr, read_data, sw_link_timeout, link_timeout;
  logic [7:0]     product_code_high, device_configuration;
  logic [3:0]     port_power_request, port_overcurrent, port_power_on;
  logic [2:0]     smbus_addr_bits;
  int             fail_count, samples_checked, cycles;

  cfg_source_model src (.mclk(mclk), .host_write(host_write),
    .eeprom_write(eeprom_write));

  hub_device_config_regs #(.num_ports(4)) dut (
    .mclk(mclk), .rst(rst), .straps(straps), .i2c_mode(i2c_mode),
    .smbus_mode(smbus_mode), .host_cfg_active(host_cfg_active),
    .eeprom_write(eeprom_write), .host_write(host_write),
    .read_addr(read_addr), .read_data(read_data),
    .force_accept_event(force_accept_event),
    .upstream_disconnect(upstream_disconnect),
    .low_power_permit(low_power_permit), .self_powered(self_powered),
    .power_switch_supported(power_switch_supported),
    .overcurrent_supported(overcurrent_supported),
    .sw_link_timeout(sw_link_timeout), .link_timeout(link_timeout),
    .port_power_request(port_power_request),
    .port_overcurrent(port_overcurrent), .port_power_on(port_power_on),
    .string_load_enable(string_load_enable),
    .string_host_write_enable(string_host_write_enable),
    .serial_load_enable(serial_load_enable),
    .serial_host_write_enable(serial_host_write_enable),
    .product_code_high(product_code_high),
    .device_configuration(device_configuration),
    .smbus_addr_bits(smbus_addr_bits));

  // ----------------------------------------------------------------------
  // clock, hang guard and helpers
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // hang guard, far above the roughly ninety cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // registered read: address at a falling edge, data after the next rise
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk) read_addr = a;
    @(negedge mclk) `CHK(read_data, exp)
  endtask

  // one-cycle pulse on a link event input
  task automatic pulse(ref logic s);
    @(negedge mclk) s = 1'b1;
    @(negedge mclk) s = 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst = 1'b1; straps = 5'b10110; i2c_mode = 1'b0; smbus_mode = 1'b1;
    host_cfg_active = 1'b1; read_addr = 8'h00; sw_link_timeout = 8'h00;
    force_accept_event = 1'b0; upstream_disconnect = 1'b0;
    self_powered = 1'b0; port_power_request = 4'h0; port_overcurrent = 4'h0;
    wait_n(3);
    `CHK(product_code_high, 8'h5a)
    rst = 1'b0;
    wait_n(6);
    `CHK(device_configuration, 8'h2c)
    `CHK(smbus_addr_bits, 3'b011)
    `CHK({power_switch_supported, overcurrent_supported}, 2'b10)
    `CHK(low_power_permit, 1'b0)
    $display("test straps done");
    pulse(force_accept_event);
    wait_n(2);
    `CHK(low_power_permit, 1'b1)
    pulse(upstream_disconnect);
    wait_n(2);
    `CHK(low_power_permit, 1'b0)
    $display("test link power done");
    src.host_wr(8'h05, 8'hff);
    rd(8'h05, 8'hfe);
    `CHK({string_host_write_enable, serial_host_write_enable}, 2'b11)
    `CHK(string_load_enable, 1'b0)
    src.host_wr(8'h04, 8'h3c);
    rd(8'h04, 8'h3c);
    rd(8'h07, 8'h00);
    host_cfg_active = 1'b0;
    src.host_wr(8'h05, 8'h00);
    rd(8'h05, 8'hfe);
    $display("test host writes done");
    for (int i = 0; i < 8; i++) begin
      sw_link_timeout = 8'h01 << i;
      wait_n(2);
      `CHK(link_timeout, 8'hff)
    end
    sw_link_timeout = 8'h00;
    wait_n(2);
    `CHK(link_timeout, 8'h00)
    self_powered = 1'b1;
    wait_n(2);
    `CHK({power_switch_supported, overcurrent_supported}, 2'b01)
    port_power_request = 4'h2;
    wait_n(2);
    `CHK(port_power_on, 4'hf)
    port_overcurrent = 4'h4;
    wait_n(4);
    `CHK(port_power_on, 4'h0)
    port_overcurrent = 4'h0;
    $display("test timeout and power done");
    smbus_mode = 1'b0;
    i2c_mode = 1'b1;
    src.eep_wr(8'h05, 8'h00);
    sw_link_timeout = 8'h01;
    wait_n(3);
    `CHK(device_configuration, 8'h00)
    `CHK(link_timeout, 8'h01)
    `CHK({power_switch_supported, overcurrent_supported}, 2'b11)
    `CHK(low_power_permit, 1'b1)
    src.eep_wr(8'h05, 8'hc0);
    wait_n(3);
    `CHK({string_load_enable, serial_load_enable}, 2'b11)
    `CHK(string_host_write_enable, 1'b0)
    src.host_wr(8'h05, 8'h00);
    src.eep_wr(8'h04, 8'h96);
    rd(8'h04, 8'h96);
    `CHK(device_configuration, 8'hc0)
    port_power_request = 4'h6;
    port_overcurrent = 4'h2;
    wait_n(4);
    `CHK(port_power_on, 4'h4)
    port_overcurrent = 4'h0;
    $display("test eeprom load done");
    pulse(force_accept_event);
    rst = 1'b1;
    wait_n(3);
    rst = 1'b0;
    wait_n(6);
    `CHK(device_configuration, 8'h2c)
    `CHK(product_code_high, 8'h5a)
    `CHK(low_power_permit, 1'b0)
    $display("test second reset done");
    print_verdict();
  end
endmodule // hub_device_config_regs_test

`default_nettype wire
